// [logic/obpl_bit_func.sv]
// Output bit function: per-source polarity, AND/OR function, result polarity.
// Assumes all inputs are registered or stable within the cycle.
`timescale 1ns/1ps
`default_nettype none

module obpl_bit_func (
  // Selected sources, A in bit 0
  input wire logic [3:0] sel,
  input wire logic [3:0] src_pol,
  input wire logic res_pol,
  input wire logic [2:0] op_type,
  // Direct sources for the non-function types
  input wire logic dflt_src,
  input wire logic mv1,
  input wire logic mv2,
  // Function result
  output logic result
);

  logic [3:0] adj;
  logic fn;

  always_comb
  begin
    adj = sel ^ src_pol;
    fn = 1'b0;
    result = 1'b0;
    case (op_type)
      obpl_pkg::OT_DEFAULT: result = dflt_src;
      obpl_pkg::OT_MV1: result = mv1;
      obpl_pkg::OT_MV2: result = mv2;
      obpl_pkg::OT_F1:
      begin
        fn = (adj[0] & adj[1]) | (adj[2] & adj[3]);
        result = fn ^ res_pol;
      end
      obpl_pkg::OT_F2:
      begin
        fn = (adj[0] | adj[1]) & (adj[2] | adj[3]);
        result = fn ^ res_pol;
      end
      obpl_pkg::OT_F3:
      begin
        fn = |adj;
        result = fn ^ res_pol;
      end
      obpl_pkg::OT_F4:
      begin
        fn = &adj;
        result = fn ^ res_pol;
      end
      default: result = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// [logic/obpl_pkg.sv]
// Constants shared by the output bit polarity and latch block.
// Assumes one system clock and a word-addressed plain register port.
package obpl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_OUT = 5;
  localparam int N_SRC = 4;
  localparam int CODE_W = 6;
  localparam int SRC_VEC_W = 64;
  localparam int TYPE_W = 3;
  localparam int LATCH_W = 2;

  // ----------------------------------------------------------------
  // Output indexes
  // ----------------------------------------------------------------
  localparam int OUT_CTRL1 = 0;
  localparam int OUT_CTRL2 = 1;
  localparam int OUT_EV1 = 2;

  // ----------------------------------------------------------------
  // Operation types
  // ----------------------------------------------------------------
  localparam logic [2:0] OT_DEFAULT = 3'h0;
  localparam logic [2:0] OT_MV1 = 3'h1;
  localparam logic [2:0] OT_MV2 = 3'h2;
  localparam logic [2:0] OT_F1 = 3'h3;
  localparam logic [2:0] OT_F2 = 3'h4;
  localparam logic [2:0] OT_F3 = 3'h5;
  localparam logic [2:0] OT_F4 = 3'h6;

  // ----------------------------------------------------------------
  // Latch modes
  // ----------------------------------------------------------------
  localparam logic [1:0] LM_NONE = 2'h0;
  localparam logic [1:0] LM_ON = 2'h1;
  localparam logic [1:0] LM_OFF = 2'h2;

  // ----------------------------------------------------------------
  // Source codes
  // ----------------------------------------------------------------
  localparam logic [5:0] SRC_OFF = 6'h00;
  localparam logic [5:0] SRC_ON = 6'h01;
  localparam logic [5:0] SRC_EV_FIRST = 6'h02;
  localparam logic [5:0] SRC_MV1 = 6'h0E;
  localparam logic [5:0] SRC_MV2 = 6'h0F;
  localparam logic [5:0] SRC_DI1 = 6'h12;
  localparam logic [5:0] SRC_DI2 = 6'h13;
  localparam logic [5:0] SRC_EV1_STAT = 6'h30;
  localparam logic [5:0] SRC_CTRL1_STAT = 6'h31;

  // ----------------------------------------------------------------
  // Register map: word index = output * 4 + field offset
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_TYPE = 2'h0;
  localparam logic [1:0] OFS_ASSIGN = 2'h1;
  localparam logic [1:0] OFS_POL = 2'h2;
  localparam logic [5:0] ADDR_RELEASE = 6'h14;
  localparam logic [5:0] ADDR_STATUS = 6'h15;
  localparam int POL_RES_BIT = 4;
  localparam int POL_LATCH_LSB = 5;
  localparam int STAT_HELD_LSB = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] TYPE_RST = 3'h0;
  localparam logic [3:0] SRC_POL_RST = 4'h0;
  localparam logic RES_POL_RST = 1'b0;
  localparam logic [1:0] LATCH_RST = 2'h0;
  localparam logic [29:0] ASSIGN_A_RST = {6'h04, 6'h03, 6'h02, 6'h0F, 6'h0E};

endpackage

// [logic/obpl_src_sel.sv]
// Source selection: picks one bit of the source vector per code.
// Assumes codes are packed with source A in the lowest field.
`timescale 1ns/1ps
`default_nettype none

module obpl_src_sel #(
  parameter int NSEL = 4
) (
  // Source vector, bit index equals source code
  input wire logic [obpl_pkg::SRC_VEC_W-1:0] src_vec,
  // Packed source codes
  input wire logic [NSEL*obpl_pkg::CODE_W-1:0] codes,
  // Selected source bits
  output logic [NSEL-1:0] sel
);

  for (genvar k = 0; k < NSEL; k++)
  begin : g_sel
    assign sel[k] = src_vec[codes[k*obpl_pkg::CODE_W +: obpl_pkg::CODE_W]];
  end

endmodule

`default_nettype wire

// [logic/obpl_top.sv]
// Output bit polarity and latch logic for two control and three event outputs.
// Assumes synchronous inputs, one clock, and a one-cycle-strobe register port.
`timescale 1ns/1ps
`default_nettype none

module obpl_top #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 32
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Which outputs are fitted
  input wire logic [obpl_pkg::N_OUT-1:0] out_present,
  // Sources
  input wire logic [4:0] internal_event,
  input wire logic first_manipulated_value_output,
  input wire logic second_manipulated_value_output,
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  // Release-all command from keys, one cycle
  input wire logic release_all,
  // Outputs: ctrl 1, ctrl 2, event 1 to 3
  output logic [obpl_pkg::N_OUT-1:0] do_out
);

  localparam int N = obpl_pkg::N_OUT;
  localparam int AW = N * obpl_pkg::CODE_W;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ADDR_W < 6)
  begin : g_bad_addr
    $error("ADDR_W must be at least 6");
  end
  if (DATA_W < 24)
  begin : g_bad_data
    $error("DATA_W must be at least 24");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] op_type_q [N];
  logic [2:0] op_type_d [N];
  logic [23:0] assign_q [N];
  logic [23:0] assign_d [N];
  logic [3:0] src_pol_q [N];
  logic [3:0] src_pol_d [N];
  logic [N-1:0] res_pol_q;
  logic [N-1:0] res_pol_d;
  logic [1:0] latch_q [N];
  logic [1:0] latch_d [N];
  logic [N-1:0] held_q;
  logic [N-1:0] held_d;
  logic [N-1:0] out_q;
  logic [N-1:0] out_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic [N-1:0] cfg_open;
  logic [N-1:0] hit_type;
  logic [N-1:0] hit_assign;
  logic [N-1:0] hit_pol;
  logic [N-1:0] latch_zero_wr;
  logic [N-1:0] clr;
  logic release_cmd;
  logic [obpl_pkg::SRC_VEC_W-1:0] src_vec;
  logic [3:0] sel_bits [N];
  logic [N-1:0] func_res;
  logic [N-1:0] dflt_vec;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      cfg_open[i] = out_present[i] && (op_type_q[i] >= obpl_pkg::OT_F1)
        && (op_type_q[i] <= obpl_pkg::OT_F4);
      hit_type[i] = (reg_addr[ADDR_W-1:2] == (ADDR_W-2)'(i)) && (reg_addr[1:0] == obpl_pkg::OFS_TYPE);
      hit_assign[i] = (reg_addr[ADDR_W-1:2] == (ADDR_W-2)'(i)) && (reg_addr[1:0] == obpl_pkg::OFS_ASSIGN);
      hit_pol[i] = (reg_addr[ADDR_W-1:2] == (ADDR_W-2)'(i)) && (reg_addr[1:0] == obpl_pkg::OFS_POL);
      latch_zero_wr[i] = reg_wr && hit_pol[i] && cfg_open[i]
        && (reg_wdata[obpl_pkg::POL_LATCH_LSB +: 2] == obpl_pkg::LM_NONE);
    end
    release_cmd = release_all
      || (reg_wr && (reg_addr == ADDR_W'(obpl_pkg::ADDR_RELEASE)) && reg_wdata[0]);
    clr = latch_zero_wr | {N{release_cmd}};
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      op_type_d[i] = op_type_q[i];
      assign_d[i] = assign_q[i];
      src_pol_d[i] = src_pol_q[i];
      res_pol_d[i] = res_pol_q[i];
      latch_d[i] = latch_q[i];
      if (reg_wr && hit_type[i] && (reg_wdata[2:0] <= obpl_pkg::OT_F4))
      begin
        op_type_d[i] = reg_wdata[2:0];
      end
      else if (reg_wr && hit_assign[i] && cfg_open[i])
      begin
        assign_d[i] = reg_wdata[23:0];
      end
      else if (reg_wr && hit_pol[i] && cfg_open[i])
      begin
        src_pol_d[i] = reg_wdata[3:0];
        res_pol_d[i] = reg_wdata[obpl_pkg::POL_RES_BIT];
        if (reg_wdata[obpl_pkg::POL_LATCH_LSB +: 2] <= obpl_pkg::LM_OFF)
        begin
          latch_d[i] = reg_wdata[obpl_pkg::POL_LATCH_LSB +: 2];
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < N; i++)
      begin
        op_type_q[i] <= obpl_pkg::TYPE_RST;
        assign_q[i] <= {18'h0, obpl_pkg::ASSIGN_A_RST[i*obpl_pkg::CODE_W +: obpl_pkg::CODE_W]};
        src_pol_q[i] <= obpl_pkg::SRC_POL_RST;
        latch_q[i] <= obpl_pkg::LATCH_RST;
      end
      res_pol_q <= {N{obpl_pkg::RES_POL_RST}};
    end
    else if (ce)
    begin
      op_type_q <= op_type_d;
      assign_q <= assign_d;
      src_pol_q <= src_pol_d;
      res_pol_q <= res_pol_d;
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------------------------------
  // Source vector and per-output function
  // ----------------------------------------------------------------
  always_comb
  begin
    src_vec = '0;
    src_vec[obpl_pkg::SRC_OFF] = 1'b0;
    src_vec[obpl_pkg::SRC_ON] = 1'b1;
    src_vec[obpl_pkg::SRC_EV_FIRST +: 5] = internal_event;
    src_vec[obpl_pkg::SRC_MV1] = first_manipulated_value_output;
    src_vec[obpl_pkg::SRC_MV2] = second_manipulated_value_output;
    src_vec[obpl_pkg::SRC_DI1] = digital_input_one;
    src_vec[obpl_pkg::SRC_DI2] = digital_input_two;
    // Own status feedback; inverting it would oscillate
    src_vec[obpl_pkg::SRC_EV1_STAT] = out_q[obpl_pkg::OUT_EV1];
    src_vec[obpl_pkg::SRC_CTRL1_STAT] = out_q[obpl_pkg::OUT_CTRL1];
    dflt_vec = {internal_event[2:0], second_manipulated_value_output, first_manipulated_value_output};
  end

  for (genvar g = 0; g < N; g++)
  begin : g_out
    obpl_src_sel #(
      .NSEL(obpl_pkg::N_SRC)
    ) u_sel (
      .src_vec(src_vec),
      .codes(assign_q[g]),
      .sel(sel_bits[g])
    );
    obpl_bit_func u_fn (
      .sel(sel_bits[g]),
      .src_pol(src_pol_q[g]),
      .res_pol(res_pol_q[g]),
      .op_type(op_type_q[g]),
      .dflt_src(dflt_vec[g]),
      .mv1(first_manipulated_value_output),
      .mv2(second_manipulated_value_output),
      .result(func_res[g])
    );
  end

  // ----------------------------------------------------------------
  // Latch and output
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      held_d[i] = held_q[i];
      if (clr[i])
      begin
        held_d[i] = 1'b0;
      end
      else if (!held_q[i] && (latch_q[i] == obpl_pkg::LM_ON) && func_res[i])
      begin
        held_d[i] = 1'b1;
      end
      else if (!held_q[i] && (latch_q[i] == obpl_pkg::LM_OFF) && out_q[i] && !func_res[i])
      begin
        held_d[i] = 1'b1;
      end
      // Latch is the last stage of the chain
      out_d[i] = (held_q[i] && !clr[i]) ? out_q[i] : func_res[i];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      held_q <= '0;
      out_q <= '0;
    end
    else if (ce)
    begin
      held_q <= held_d;
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd && (reg_addr == ADDR_W'(obpl_pkg::ADDR_STATUS)))
    begin
      rdata_d[N-1:0] = out_q;
      rdata_d[obpl_pkg::STAT_HELD_LSB +: N] = held_q;
    end
    else if (reg_rd)
    begin
      for (int i = 0; i < N; i++)
      begin
        if (hit_type[i])
        begin
          rdata_d[2:0] = op_type_q[i];
        end
        else if (hit_assign[i] && cfg_open[i])
        begin
          rdata_d[23:0] = assign_q[i];
        end
        else if (hit_pol[i] && cfg_open[i])
        begin
          rdata_d[3:0] = src_pol_q[i];
          rdata_d[obpl_pkg::POL_RES_BIT] = res_pol_q[i];
          rdata_d[obpl_pkg::POL_LATCH_LSB +: 2] = latch_q[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else if (ce)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign do_out = out_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] adj0;
  assign adj0 = sel_bits[0] ^ src_pol_q[0];

  property p_pol_reset;
    @(posedge core_clk) $past(rst) |-> (src_pol_q[0] == 4'h0) && (src_pol_q[4] == 4'h0);
  endproperty
  a_pol_reset: assert property (p_pol_reset) else $error("source polarity not zero after reset");

  property p_f3_pol;
    @(posedge core_clk) disable iff (rst)
      ce && !held_q[2] && (op_type_q[2] == obpl_pkg::OT_F3)
      |=> out_q[2] == ($past(|(sel_bits[2] ^ src_pol_q[2])) ^ $past(res_pol_q[2]));
  endproperty
  a_f3_pol: assert property (p_f3_pol) else $error("function 3 result wrong");

  property p_f4_res;
    @(posedge core_clk) disable iff (rst)
      ce && !held_q[2] && (op_type_q[2] == obpl_pkg::OT_F4)
      |=> out_q[2] == ($past(&(sel_bits[2] ^ src_pol_q[2])) ^ $past(res_pol_q[2]));
  endproperty
  a_f4_res: assert property (p_f4_res) else $error("result polarity not applied");

  property p_latch_on;
    @(posedge core_clk) disable iff (rst)
      ce && held_q[4] && out_q[4] && !clr[4] |=> out_q[4] && held_q[4];
  endproperty
  a_latch_on: assert property (p_latch_on) else $error("ON latch lost");

  property p_no_reset_latch;
    @(posedge core_clk) $past(rst) |-> (held_q == '0) && (out_q == '0);
  endproperty
  a_no_reset_latch: assert property (p_no_reset_latch) else $error("latch held after reset");

  property p_release;
    @(posedge core_clk) disable iff (rst)
      ce && release_cmd |=> held_q == '0;
  endproperty
  a_release: assert property (p_release) else $error("release did not clear latches");

  property p_locked;
    @(posedge core_clk) disable iff (rst)
      ce && reg_wr && hit_pol[0] && !cfg_open[0] |=> $stable(src_pol_q[0]) && $stable(latch_q[0]);
  endproperty
  a_locked: assert property (p_locked) else $error("closed settings changed");

  property p_f1;
    @(posedge core_clk) disable iff (rst)
      ce && !held_q[0] && (op_type_q[0] == obpl_pkg::OT_F1)
      |=> out_q[0] == ($past((adj0[0] & adj0[1]) | (adj0[2] & adj0[3])) ^ $past(res_pol_q[0]));
  endproperty
  a_f1: assert property (p_f1) else $error("function 1 result wrong");

  property p_default;
    @(posedge core_clk) disable iff (rst)
      ce && !held_q[2] && (op_type_q[2] == obpl_pkg::OT_DEFAULT) |=> out_q[2] == $past(internal_event[0]);
  endproperty
  a_default: assert property (p_default) else $error("default source wrong");

endmodule

`default_nettype wire

// [verif/obpl_top_test.sv]
// Self-checking bench for the output bit polarity and latch block.
// Assumes obpl_pkg and obpl_top are compiled first; drives all ports itself.
`timescale 1ns/1ps
`default_nettype none

module obpl_top_test;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic core_clk;
  logic rst;
  logic ce;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic [4:0] present;
  logic [4:0] ev;
  logic mvo_first;
  logic mvo_second;
  logic din_one;
  logic din_two;
  logic rel;
  logic [4:0] do_out;
  int error_cnt;
  int checked;

  obpl_top #(.ADDR_W(6), .DATA_W(32)) DUT (
    .core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_present(present),
    .internal_event(ev), .first_manipulated_value_output(mvo_first),
    .second_manipulated_value_output(mvo_second), .digital_input_one(din_one),
    .digital_input_two(din_two), .release_all(rel), .do_out(do_out)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic cfg(input int o, input logic [2:0] t, input logic [23:0] asg, input logic [6:0] pol);
    wr(6'(o * 4), {29'h0000000, t});
    wr(6'(o * 4 + 1), {8'h00, asg});
    wr(6'(o * 4 + 2), {25'h0000000, pol});
  endtask

  task automatic see(input string w, input int b, input logic e);
    repeat (3) @(posedge core_clk);
    #1 chk(w, {31'h00000000, do_out[b]}, {31'h00000000, e});
  endtask

  task automatic drv(input logic [4:0] v, input logic s);
    @(posedge core_clk);
    ev <= v;
    mvo_first <= s;
    mvo_second <= s;
    din_one <= s;
    din_two <= s;
  endtask

  task automatic pulse_rel;
    @(posedge core_clk);
    rel <= 1'b1;
    @(posedge core_clk);
    rel <= 1'b0;
  endtask

  function automatic logic fexp(input logic [2:0] t, input logic [3:0] x);
    case (t)
      3'h3: return (x[0] & x[1]) | (x[2] & x[3]);
      3'h4: return (x[0] | x[1]) & (x[2] | x[3]);
      3'h5: return |x;
      default: return &x;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rd(6'h00); chk("type0", rd_val, 32'h00000000);
    wr(6'h02, 32'h0000001F);
    rd(6'h02); chk("pol0 hidden", rd_val, 32'h00000000);
    wr(6'h00, 32'h00000003);
    rd(6'h02); chk("pol0 reset", rd_val, 32'h00000000);
    rd(6'h01); chk("assign0 reset", rd_val, 32'h0000000E);
    rd(6'h3F); chk("unmapped", rd_val, 32'h00000000);
    wr(6'h00, 32'h00000000);
  endtask

  task automatic t_default;
    @(posedge core_clk);
    mvo_first <= 1'b1;
    see("ctrl1 default", 0, 1'b1);
    @(posedge core_clk);
    mvo_first <= 1'b0;
    mvo_second <= 1'b1;
    ev <= 5'h06;
    repeat (3) @(posedge core_clk);
    #1 chk("defaults", {27'h0000000, do_out}, 32'h0000001A);
    drv(5'h19, 1'b0);
    see("ev1 default", 2, 1'b1);
    see("ev2 default", 3, 1'b0);
  endtask

  // Feedback codes 48 and 49 are never given an inverted polarity here
  task automatic t_functions;
    logic [6:0] pl [2];
    pl[0] = 7'h00;
    pl[1] = 7'h19;
    for (int t = 3; t <= 6; t++)
      for (int p = 0; p < 2; p++)
      begin
        cfg(2, 3'(t), 24'h1440C2, pl[p]);
        for (int n = 0; n < 16; n++)
        begin
          drv({1'b0, 4'(n)}, 1'b0);
          see("function", 2, fexp(3'(t), 4'(n) ^ pl[p][3:0]) ^ pl[p][4]);
        end
        rd(6'h0A); chk("pol2 readback", rd_val, {25'h0000000, pl[p]});
      end
  endtask

  task automatic t_sources;
    logic [5:0] codes [8];
    codes = '{6'h00, 6'h01, 6'h06, 6'h0E, 6'h0F, 6'h12, 6'h13, 6'h07};
    for (int i = 0; i < 8; i++)
    begin
      cfg(3, 3'h5, {18'h00000, codes[i]}, 7'h00);
      drv(5'h1F, 1'b1);
      see("source high", 3, codes[i] != 6'h00 && codes[i] != 6'h07);
      drv(5'h00, 1'b0);
      see("source low", 3, codes[i] == 6'h01);
    end
  endtask

  task automatic arm4;
    drv(5'h10, 1'b0);
    see("on", 4, 1'b1);
    drv(5'h00, 1'b0);
    see("held on", 4, 1'b1);
  endtask

  task automatic t_latch_on;
    cfg(4, 3'h5, 24'h000006, 7'h20);
    drv(5'h00, 1'b0);
    see("follow", 4, 1'b0);
    arm4;
    rd(6'h15); chk("held flag", {31'h00000000, rd_val[9]}, 32'h00000001);
    pulse_rel;
    see("key release", 4, 1'b0);
    arm4;
    wr(6'h14, 32'h00000001);
    see("reg release", 4, 1'b0);
    arm4;
    wr(6'h12, 32'h00000000);
    see("mode zero release", 4, 1'b0);
    wr(6'h12, 32'h00000020);
    arm4;
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("reset release", {27'h0000000, do_out}, 32'h00000000);
  endtask

  task automatic t_latch_off;
    cfg(3, 3'h5, 24'h000003, 7'h40);
    drv(5'h00, 1'b0);
    see("init off", 3, 1'b0);
    drv(5'h02, 1'b0);
    see("off mode on", 3, 1'b1);
    drv(5'h00, 1'b0);
    see("off", 3, 1'b0);
    drv(5'h02, 1'b0);
    see("held off", 3, 1'b0);
    pulse_rel;
    see("off released", 3, 1'b1);
  endtask

  task automatic t_absent;
    @(posedge core_clk);
    present <= 5'h1E;
    wr(6'h00, 32'h00000003);
    wr(6'h02, 32'h0000001F);
    rd(6'h02); chk("absent read", rd_val, 32'h00000000);
    @(posedge core_clk);
    present <= 5'h1F;
    wr(6'h00, 32'h00000003);
    rd(6'h02); chk("absent write", rd_val, 32'h00000000);
    wr(6'h00, 32'h00000000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 6'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    present = 5'h1F;
    ev = 5'h00;
    mvo_first = 1'b0;
    mvo_second = 1'b0;
    din_one = 1'b0;
    din_two = 1'b0;
    rel = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset_values;
    t_default;
    t_functions;
    t_sources;
    t_latch_on;
    t_latch_off;
    t_absent;
    tally_and_finish;
  end

  // The scenarios need under a thousand cycles; this allows ample margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
